// File: bench/host_pins.sv
// Purpose: Host logic that drives the FIFO pins from a small operation code.
// Assumes: The code changes just after a rising clk_sys edge.
// Notes: Idle data lines show the inverted value so stale data is never taken as fresh.
`timescale 1ns/1ps
module host_pins (
  input wire logic [2:0] op,
  input wire logic [8:0] din,
  output logic reset_n,
  output logic [8:0] data_in,
  output logic write_enable_primary_n,
  output logic write_enable_secondary_or_offset_load,
  output logic read_enable_a_n,
  output logic read_enable_b_n
);
  // Codes: 1 write, 2 read, 3 offset write, 4 offset read, 5 and 6 reset in load or
  // two-enable mode. Only one code is live, so offset writes and reads never overlap.
  assign write_enable_primary_n = !(op == 3'h1 || op == 3'h3);
  // The load pin is held low through reset when load mode is wanted.
  assign write_enable_secondary_or_offset_load = !(op == 3'h3 || op == 3'h4 || op == 3'h5);
  // Both read enables move together.
  assign read_enable_a_n = !(op == 3'h2 || op == 3'h4);
  assign read_enable_b_n = !(op == 3'h2 || op == 3'h4);
  // FIFO reset and data lines.
  assign reset_n = !(op == 3'h5 || op == 3'h6);
  assign data_in = (op == 3'h1 || op == 3'h3) ? din : ~din;
endmodule

// File: bench/sync_fifo_offset_flags_tb.sv
// Purpose: Self-checking bench for the FIFO flags, offset loading and register bus.
// Assumes: DEPTH 64 and two synchroniser stages; flags may lag by a few edges.
// Notes: Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
`include "fifo_flags_params.svh"
module sync_fifo_offset_flags_tb;
  import fifo_flags_pkg::*;
  typedef struct {int cnt; logic [3:0] fl;} row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] op = 3'h0;
  logic [8:0] din = 9'h000;
  logic reset_n, we_p_n, we_s, re_a_n, re_b_n, ef_n, ff_n, aef_n, aff_n;
  logic [8:0] data_in, data_out;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rr;
  logic [3:0] flags;
  logic [31:0] st_exp;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int wcnt = 0;
  row_t rows[5] = '{'{3, 4'hd}, '{4, 4'hf}, '{58, 4'hf}, '{59, 4'hb}, '{64, 4'h3}};
  // With one device in the bench, its empty and full flags are already the composite ones.
  assign flags = {ff_n, aff_n, aef_n, ef_n};
  host_pins host_pins_inst (.op(op), .din(din), .reset_n(reset_n), .data_in(data_in),
    .write_enable_primary_n(we_p_n), .write_enable_secondary_or_offset_load(we_s),
    .read_enable_a_n(re_a_n), .read_enable_b_n(re_b_n));
  sync_fifo_offset_flags #(.DEPTH(64), .SYNC_STAGES(2)) sync_fifo_offset_flags_inst (
    .clk_sys(clk_sys), .rst(rst), .reset_n(reset_n), .data_in(data_in),
    .write_enable_primary_n(we_p_n), .write_enable_secondary_or_offset_load(we_s),
    .read_enable_a_n(re_a_n), .read_enable_b_n(re_b_n), .data_out(data_out),
    .empty_flag_n(ef_n), .full_flag_n(ff_n), .almost_empty_flag_n(aef_n),
    .almost_full_flag_n(aff_n), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // Clock of 40 ns period.
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // Prints the counts and the verdict, then stops.
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sets the pin operation for the next edge.
  task act(input logic [2:0] o, input logic [8:0] d);
    @(posedge clk_sys);
    op <= o;
    din <= d;
  endtask
  // Reads four offset bytes back to back and compares each.
  task rb4(input logic [35:0] e);
    act(3'h4, 9'h000);
    for (int i = 0; i < 4; i++) begin
      act((i < 3) ? 3'h4 : 3'h0, 9'h000);
      @(negedge clk_sys);
      check("offset byte", {23'h0, data_out}, {23'h0, e[35-9*i -: 9]});
    end
  endtask
  // Bus write: address and data offered together, each released when taken.
  task axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        rr = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // Bus read: data and response taken at the edge where rvalid is seen.
  task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // Cuts a hang short.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      give_verdict;
    end
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check("reset flags", {28'h0, flags}, 32'hc);
    check("reset data", {23'h0, data_out}, 32'h0);
    $display("test reset done");
    act(3'h3, 9'h055);
    act(3'h3, 9'h0aa);
    act(3'h0, 9'h000);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("no store", {28'h0, flags}, 32'hc);
    act(3'h1, 9'h011);
    act(3'h0, 9'h000);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("one stored", {28'h0, flags}, 32'hd);
    act(3'h6, 9'h000);
    act(3'h0, 9'h000);
    @(negedge clk_sys);
    check("reset clears", {28'h0, flags}, 32'hc);
    $display("test two-enable mode done");
    act(3'h5, 9'h000);
    act(3'h5, 9'h000);
    act(3'h0, 9'h000);
    rb4({9'h007, 9'h000, 9'h007, 9'h000});
    act(3'h3, 9'h004);
    act(3'h3, 9'h000);
    act(3'h3, 9'h005);
    act(3'h3, 9'h000);
    act(3'h3, 9'h003);
    act(3'h0, 9'h000);
    rb4({9'h000, 9'h005, 9'h000, 9'h003});
    $display("test offset load done");
    foreach (rows[k]) begin
      while (wcnt < rows[k].cnt) begin
        wcnt++;
        act(3'h1, wcnt[8:0]);
      end
      act(3'h0, 9'h000);
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      check("fill flags", {28'h0, flags}, {28'h0, rows[k].fl});
    end
    act(3'h1, 9'h1ff);
    act(3'h2, 9'h000);
    for (int i = 1; i <= 64; i++) begin
      act((i < 64) ? 3'h2 : 3'h0, 9'h000);
      @(negedge clk_sys);
      check("word", {23'h0, data_out}, i);
    end
    act(3'h2, 9'h000);
    act(3'h2, 9'h000);
    act(3'h0, 9'h000);
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    check("last word", {23'h0, data_out}, 32'h40);
    check("drained flags", {28'h0, flags}, 32'hc);
    $display("test fill and drain done");
    axi_rd(`REG_STATUS_ADDR, rd, rr);
    st_exp = (32'h1 << `ST_AFULL_BIT) | (32'h1 << `ST_FULL_BIT) | (32'h1 << `ST_LOADMODE_BIT);
    check("status", rd, st_exp);
    axi_wr(`REG_EMPTY_OFS_ADDR, 32'h0000_0002);
    check("write resp", {30'h0, rr}, {30'h0, RESP_OKAY});
    axi_rd(`REG_EMPTY_OFS_ADDR, rd, rr);
    check("empty offset", rd, 32'h2);
    axi_rd(32'h0000_000c, rd, rr);
    check("unmapped resp", {30'h0, rr}, {30'h0, RESP_SLVERR});
    $display("test register bus done");
    give_verdict;
  end
endmodule

// File: logic/fifo_flags_params.svh
// Purpose: Constants for the nine-bit FIFO with programmable almost flags.
// Assumes: One clock, clk_sys at 25 MHz; write and read ports share it.
// Notes: Offsets, field positions and reset values live here; types live in the package.
// How it works
// - In load mode, writes fill empty-low, empty-high, full-low, full-high in turn.
// - After full-high, the next load write selects empty-low again.
// - Leaving load mode takes a FIFO reset, which returns the selector to empty-low.
// - Load mode with the load pin and both read enables low reads the selected offset byte out.
// - Almost-empty threshold n is empty-high byte above empty-low byte.
// - Almost-empty flag is low at n or fewer words, high above n.
// - Almost-full threshold m is full-high byte above full-low byte.
// - Almost-full flag goes low once stored words reach depth minus m.
// - Almost-full flag returns high when free locations exceed m.
// - Without programming, n equals seven.
// - Without programming, m equals seven.
// - Full flag low at full depth and blocks every FIFO write.
// - Full flag changes only on write-side clock edges.
// - Empty flag low with no unread words and blocks every FIFO read.
// - Empty flag changes only on read-side clock edges.
// - During FIFO reset the load pin level picks load mode or second enable.
// - Second-enable mode stores a word when primary low and secondary high.
// - Both read enables low, not empty and no offset read presents the next stored word.
// - When empty, the output keeps the last word validly read.
`ifndef FIFO_FLAGS_PARAMS_SVH
`define FIFO_FLAGS_PARAMS_SVH
`define FIFO_DATA_W 9
`define FIFO_DEPTH 64
`define SYNC_STAGES 2
`define OFFSET_DEFAULT_N 16'h0007
`define OFFSET_DEFAULT_M 16'h0007
`define REG_STATUS_ADDR 32'h0000_0000
`define REG_EMPTY_OFS_ADDR 32'h0000_0004
`define REG_FULL_OFS_ADDR 32'h0000_0008
`define ST_EMPTY_BIT 0
`define ST_AEMPTY_BIT 1
`define ST_AFULL_BIT 2
`define ST_FULL_BIT 3
`define ST_LOADMODE_BIT 4
`define ST_LEVEL_LSB 16
`endif

// File: logic/fifo_flags_pkg.sv
// Purpose: Types shared by the FIFO flag logic.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: Codes are written out so a waveform reads directly.
package fifo_flags_pkg;
  typedef enum logic [1:0] {
    SEL_EMPTY_LO = 2'b00,
    SEL_EMPTY_HI = 2'b01,
    SEL_FULL_LO = 2'b10,
    SEL_FULL_HI = 2'b11
  } offset_sel_t;
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_t;
  typedef enum logic [1:0] {
    IDX_STATUS = 2'b00,
    IDX_EMPTY = 2'b01,
    IDX_FULL = 2'b10,
    IDX_NONE = 2'b11
  } reg_idx_t;
endpackage

// File: logic/offset_bank.sv
// Purpose: Four offset bytes, their cyclic selector and the two thresholds.
// Assumes: Pin and bus writes are already qualified by the FIFO core.
// Notes: A pin load write wins over a bus write to the same byte.
`timescale 1ns/1ps
`include "fifo_flags_params.svh"
module offset_bank
  import fifo_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  offset_bus_if.bank ob
);
  localparam int AW = $bits(ob.empty_thr);
  logic [7:0] ofs_reg [4];
  offset_sel_t sel_reg;

  // Each byte loads its default on reset, then pin writes, then bus writes.
  for (genvar i = 0; i < 4; i++) begin : g_byte
    localparam logic [15:0] DEF_WORD = (i < 2) ? `OFFSET_DEFAULT_N : `OFFSET_DEFAULT_M;
    localparam logic [7:0] DEF_BYTE = DEF_WORD[8*(i%2) +: 8];
    logic sw_hit;
    assign sw_hit = ((i < 2) ? ob.sw_wr_empty : ob.sw_wr_full) && ob.sw_strb[i%2];
    always_ff @(posedge clk_sys) begin
      if (rst || clr) begin
        ofs_reg[i] <= DEF_BYTE;
      end else if (ob.pin_wr && (sel_reg == 2'(i))) begin
        ofs_reg[i] <= ob.pin_data;
      end else if (sw_hit) begin
        ofs_reg[i] <= ob.sw_wdata[8*(i%2) +: 8];
      end
    end
  end

  // The selector steps once per load access and wraps after the last byte.
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      sel_reg <= SEL_EMPTY_LO;
    end else if (ob.pin_wr || ob.pin_rd) begin
      sel_reg <= offset_sel_t'(sel_reg + 2'd1);
    end
  end

  // Thresholds use only as many bits as the depth needs.
  assign ob.empty_off = {ofs_reg[1], ofs_reg[0]};
  assign ob.full_off = {ofs_reg[3], ofs_reg[2]};
  assign ob.empty_thr = ob.empty_off[AW-1:0];
  assign ob.full_thr = ob.full_off[AW-1:0];
  assign ob.sel_byte = ofs_reg[sel_reg];
  assign ob.sel = sel_reg;

  a_ptr_advance: assert property (@(posedge clk_sys) disable iff (rst)
    (ob.pin_wr || ob.pin_rd) && !clr |=> sel_reg == offset_sel_t'($past(sel_reg) + 2'd1))
    else $error("Offset selector did not step after a load access.");
  a_ptr_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    ob.pin_wr && !clr && sel_reg == SEL_FULL_HI |=> sel_reg == SEL_EMPTY_LO)
    else $error("Offset selector did not wrap to the first byte.");
  a_ptr_holds: assert property (@(posedge clk_sys) disable iff (rst)
    !ob.pin_wr && !ob.pin_rd && !clr |=> $stable(sel_reg))
    else $error("Offset selector moved without a load access.");
  a_default_thr: assert property (@(posedge clk_sys) disable iff (rst)
    clr |=> ob.empty_off == `OFFSET_DEFAULT_N && ob.full_off == `OFFSET_DEFAULT_M)
    else $error("Offsets did not return to their defaults after reset.");
endmodule

// File: logic/offset_bus_if.sv
// Purpose: Carries offset-bank strobes, data and thresholds inside the FIFO.
// Assumes: AW is the FIFO address width.
// Notes: The bank drives thresholds; the FIFO core drives strobes.
`timescale 1ns/1ps
interface offset_bus_if #(parameter int AW = 6) ();
  logic pin_wr;
  logic pin_rd;
  logic [7:0] pin_data;
  logic sw_wr_empty;
  logic sw_wr_full;
  logic [15:0] sw_wdata;
  logic [1:0] sw_strb;
  logic [7:0] sel_byte;
  logic [1:0] sel;
  logic [15:0] empty_off;
  logic [15:0] full_off;
  logic [AW-1:0] empty_thr;
  logic [AW-1:0] full_thr;
  modport bank (input pin_wr, pin_rd, pin_data, sw_wr_empty, sw_wr_full, sw_wdata, sw_strb,
                output sel_byte, sel, empty_off, full_off, empty_thr, full_thr);
  modport user (output pin_wr, pin_rd, pin_data, sw_wr_empty, sw_wr_full, sw_wdata, sw_strb,
                input sel_byte, sel, empty_off, full_off, empty_thr, full_thr);
endinterface

// File: logic/ptr_sync.sv
// Purpose: Carries a pointer copy to the opposite side through register stages.
// Assumes: Source and destination share clk_sys.
// Notes: Stage zero is read only by stage one.
`timescale 1ns/1ps
`include "fifo_flags_params.svh"
module ptr_sync #(
  parameter int W = 7,
  parameter int STAGES = `SYNC_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  input wire logic [W-1:0] src,
  output logic [W-1:0] dst
);
  logic [W-1:0] stage_reg [STAGES];

  // Each stage copies the one before it; a FIFO reset empties the chain.
  for (genvar i = 0; i < STAGES; i++) begin : g_stage
    always_ff @(posedge clk_sys) begin
      if (rst || clr) begin
        stage_reg[i] <= '0;
      end else if (i == 0) begin
        stage_reg[i] <= src;
      end else begin
        stage_reg[i] <= stage_reg[(i == 0) ? 0 : i - 1];
      end
    end
  end

  assign dst = stage_reg[STAGES-1];
endmodule

// File: logic/sync_fifo_offset_flags.sv
// Purpose: Nine-bit FIFO with empty, full and programmable almost flags.
// Assumes: Pins are synchronous to clk_sys; write and read sides share that clock.
// Notes: Offsets are reachable both through the load pin and over AXI4-Lite.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "fifo_flags_params.svh"
module sync_fifo_offset_flags
  import fifo_flags_pkg::*;
#(
  parameter int DATA_W = `FIFO_DATA_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int SYNC_STAGES = `SYNC_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic write_enable_primary_n,
  input wire logic write_enable_secondary_or_offset_load,
  input wire logic read_enable_a_n,
  input wire logic read_enable_b_n,
  output logic [DATA_W-1:0] data_out,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic almost_empty_flag_n,
  output logic almost_full_flag_n,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // Address width of the array; pointers carry one extra wrap bit.
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  // Maps a bus byte address onto one of the registers.
  function automatic reg_idx_t decode_addr(input logic [31:0] a);
    if (a == `REG_STATUS_ADDR) begin
      return IDX_STATUS;
    end else if (a == `REG_EMPTY_OFS_ADDR) begin
      return IDX_EMPTY;
    end else if (a == `REG_FULL_OFS_ADDR) begin
      return IDX_FULL;
    end
    return IDX_NONE;
  endfunction

  offset_bus_if #(.AW(AW)) ob ();

  logic clr;
  logic load_mode_reg;
  logic offset_load_n;
  logic wr_do;
  logic rd_do;
  logic ofs_wr;
  logic ofs_rd;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] rd_word;
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] wr_ptr_next;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW-1:0] rd_ptr_next;
  logic [PW-1:0] wr_ptr_sync;
  logic [PW-1:0] rd_ptr_sync;
  logic [PW-1:0] wr_level;
  logic [PW-1:0] rd_level;
  logic [PW-1:0] af_limit;
  logic [DATA_W-1:0] data_out_reg;
  logic empty_flag_n_reg;
  logic full_flag_n_reg;
  logic almost_empty_flag_n_reg;
  logic almost_full_flag_n_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic bus_wr_fire;
  reg_idx_t wr_idx;
  logic [31:0] status_word;

  // A low reset_n pin is the FIFO's own reset: it empties the FIFO.
  assign clr = !reset_n;

  // The dual-purpose pin level is caught while reset_n is low.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      load_mode_reg <= 1'b0;
    end else if (clr) begin
      load_mode_reg <= !write_enable_secondary_or_offset_load;
    end
  end

  // In load mode the dual-purpose pin acts as an active-low offset load.
  assign offset_load_n = write_enable_secondary_or_offset_load;

  // Pin accesses to the offset bank happen only in load mode with the load pin low.
  assign ofs_wr = load_mode_reg && !offset_load_n && !write_enable_primary_n && !clr;
  assign ofs_rd = load_mode_reg && !offset_load_n && !read_enable_a_n
                  && !read_enable_b_n && !clr;

  // A FIFO write needs primary low, the second pin high and room left.
  assign wr_do = !write_enable_primary_n && write_enable_secondary_or_offset_load
                 && full_flag_n_reg && !clr;

  // A FIFO read needs both enables low, a word stored and no offset read.
  assign rd_do = !read_enable_a_n && !read_enable_b_n && empty_flag_n_reg
                 && !ofs_rd && !clr;

  assign wr_ptr_next = wr_ptr_reg + {{AW{1'b0}}, wr_do};
  assign rd_ptr_next = rd_ptr_reg + {{AW{1'b0}}, rd_do};
  assign rd_word = mem[rd_ptr_reg[AW-1:0]];

  // Storage array written at the write pointer.
  always_ff @(posedge clk_sys) begin
    if (wr_do) begin
      mem[wr_ptr_reg[AW-1:0]] <= data_in;
    end
  end

  // Write pointer advances on each accepted write.
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      wr_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
    end
  end

  // Read pointer advances on each accepted read.
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      rd_ptr_reg <= '0;
    end else begin
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Each side sees the other side's pointer only through a stage chain.
  ptr_sync #(.W(PW), .STAGES(SYNC_STAGES)) u_wr_to_rd (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(clr),
    .src(wr_ptr_reg),
    .dst(wr_ptr_sync)
  );

  ptr_sync #(.W(PW), .STAGES(SYNC_STAGES)) u_rd_to_wr (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(clr),
    .src(rd_ptr_reg),
    .dst(rd_ptr_sync)
  );

  // Offset bank strobes and bus write data.
  assign ob.pin_wr = ofs_wr;
  assign ob.pin_rd = ofs_rd;
  assign ob.pin_data = data_in[7:0];
  assign ob.sw_wr_empty = bus_wr_fire && (wr_idx == IDX_EMPTY);
  assign ob.sw_wr_full = bus_wr_fire && (wr_idx == IDX_FULL);
  assign ob.sw_wdata = wdata_reg[15:0];
  assign ob.sw_strb = wstrb_reg[1:0];

  offset_bank u_bank (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(clr),
    .ob(ob)
  );

  // Levels seen by each side, using the next own pointer and the copied other.
  assign wr_level = wr_ptr_next - rd_ptr_sync;
  assign rd_level = wr_ptr_sync - rd_ptr_next;
  assign af_limit = DEPTH_P - {1'b0, ob.full_thr};

  // Write-side flags: full and almost full move only with the write side.
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      full_flag_n_reg <= 1'b1;
      almost_full_flag_n_reg <= 1'b1;
    end else begin
      full_flag_n_reg <= (wr_level != DEPTH_P);
      almost_full_flag_n_reg <= (wr_level < af_limit);
    end
  end

  // Read-side flags: empty and almost empty move only with the read side.
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      empty_flag_n_reg <= 1'b0;
      almost_empty_flag_n_reg <= 1'b0;
    end else begin
      empty_flag_n_reg <= (rd_level != '0);
      almost_empty_flag_n_reg <= (rd_level > {1'b0, ob.empty_thr});
    end
  end

  // Output word: next stored word on a read, offset byte on a readback.
  // With nothing read the last valid word stays on the pins.
  always_ff @(posedge clk_sys) begin
    if (rst || clr) begin
      data_out_reg <= '0;
    end else if (rd_do) begin
      data_out_reg <= rd_word;
    end else if (ofs_rd) begin
      data_out_reg <= {{(DATA_W-8){1'b0}}, ob.sel_byte};
    end
  end

  assign data_out = data_out_reg;
  assign empty_flag_n = empty_flag_n_reg;
  assign full_flag_n = full_flag_n_reg;
  assign almost_empty_flag_n = almost_empty_flag_n_reg;
  assign almost_full_flag_n = almost_full_flag_n_reg;

  // Status word: flags, mode and the write-side level.
  always_comb begin
    status_word = '0;
    status_word[`ST_EMPTY_BIT] = empty_flag_n_reg;
    status_word[`ST_AEMPTY_BIT] = almost_empty_flag_n_reg;
    status_word[`ST_AFULL_BIT] = almost_full_flag_n_reg;
    status_word[`ST_FULL_BIT] = full_flag_n_reg;
    status_word[`ST_LOADMODE_BIT] = load_mode_reg;
    status_word[`ST_LEVEL_LSB +: PW] = wr_ptr_reg - rd_ptr_sync;
  end

  // Write address and data are taken independently and held until answered.
  assign awready = !aw_hold_reg;
  assign wready = !w_hold_reg;
  assign bus_wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_idx = decode_addr(awaddr_reg);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (awvalid && !aw_hold_reg) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg <= awaddr;
    end else if (bus_wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      w_hold_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (wvalid && !w_hold_reg) begin
      w_hold_reg <= 1'b1;
      wdata_reg <= wdata;
      wstrb_reg <= wstrb;
    end else if (bus_wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  // Write response: unmapped addresses answer with a slave error.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (bus_wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_idx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;

  // Read channel: one read at a time, answered the cycle after the address.
  assign arready = !rvalid_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      unique case (decode_addr(araddr))
        IDX_STATUS: rdata_reg <= status_word;
        IDX_EMPTY: rdata_reg <= {16'h0000, ob.empty_off};
        IDX_FULL: rdata_reg <= {16'h0000, ob.full_off};
        IDX_NONE: begin
          rdata_reg <= '0;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = rdata_reg;

  a_full_blocks_write: assert property (@(posedge clk_sys) disable iff (rst)
    !full_flag_n_reg && reset_n |=> wr_ptr_reg == $past(wr_ptr_reg))
    else $error("Write pointer moved while the FIFO was full.");
  a_empty_blocks_read: assert property (@(posedge clk_sys) disable iff (rst)
    !empty_flag_n_reg && reset_n |=> rd_ptr_reg == $past(rd_ptr_reg))
    else $error("Read pointer moved while the FIFO was empty.");
  a_empty_means_ae: assert property (@(posedge clk_sys) disable iff (rst)
    !empty_flag_n_reg |-> !almost_empty_flag_n_reg)
    else $error("Almost-empty flag high while empty flag low.");
  a_full_means_af: assert property (@(posedge clk_sys) disable iff (rst)
    !full_flag_n_reg |-> !almost_full_flag_n_reg)
    else $error("Almost-full flag high while full flag low.");
  a_empty_holds_out: assert property (@(posedge clk_sys) disable iff (rst)
    !empty_flag_n_reg && !ofs_rd && reset_n |=> $stable(data_out))
    else $error("Output word changed while empty.");
  a_readback_data: assert property (@(posedge clk_sys) disable iff (rst)
    ofs_rd |=> data_out[7:0] == $past(ob.sel_byte))
    else $error("Offset readback did not show the selected byte.");
  a_read_presents: assert property (@(posedge clk_sys) disable iff (rst)
    rd_do |=> data_out == $past(rd_word) ##1 1'b1)
    else $error("Read did not present the stored word.");
  a_mode_capture: assert property (@(posedge clk_sys) disable iff (rst)
    !reset_n |=> load_mode_reg == !$past(write_enable_secondary_or_offset_load))
    else $error("Configuration was not caught during FIFO reset.");
  a_ae_threshold: assert property (@(posedge clk_sys) disable iff (rst)
    reset_n && rd_level <= {1'b0, ob.empty_thr} |=> !almost_empty_flag_n_reg)
    else $error("Almost-empty flag high at or below the threshold.");
  a_sel_reset: assert property (@(posedge clk_sys) disable iff (rst)
    !reset_n |=> ob.sel == SEL_EMPTY_LO)
    else $error("Offset selector did not return to the first byte on reset.");
endmodule
